// File: core/rsp_buf2.v
// Purpose: Two-entry skid buffer with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Full when both entries hold data; in_ready drops then
`timescale 1ns/1ps
module rsp_buf2 #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg rdy_q;
  wire push;
  wire pop;

  // Registered ready so the top output comes from a flip-flop
  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @*
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != 2'h2);
    end
  end
endmodule

// File: core/rsp_defs.vh
// Purpose: Constants for the serial handshake port with status indicators
// Assumes: 250 MHz system clock, 8N1 framing
// Notes: Divider values select bit rates up to the top supported rate
`ifndef RSP_DEFS_VH
`define RSP_DEFS_VH

// ----------------------------------------
// Clock and rates
// ----------------------------------------
`define RSP_CLK_HZ 250000000
`define RSP_MAX_BAUD 76800
// Smallest legal divider: clocks per bit at the top rate
`define RSP_DIV_MIN ((`RSP_CLK_HZ + `RSP_MAX_BAUD - 1) / `RSP_MAX_BAUD)
`define RSP_DIV_W 16
`define RSP_DIV_RST 16'h0cb8

// ----------------------------------------
// Timing
// ----------------------------------------
// Break: line low longer than this many bit times
`define RSP_BRK_BITS 20
// Minimum indicator on-time in ms, converted to cycles
`define RSP_LED_MS 50
`define RSP_LED_CYC (`RSP_CLK_HZ / 1000 * `RSP_LED_MS)
`define RSP_LED_W 24

`endif

// File: core/rsp_port.v
// Purpose: Full-duplex serial port with modem lines and status indicators
// Assumes: 250 MHz CLK_SYS, SYS_RST synchronous active high, 8N1 frames
// Notes: Pin inputs pass two flip-flops before use
`timescale 1ns/1ps
`include "rsp_defs.vh"
module rsp_port (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [15:0] BAUD_DIV,
  input wire [7:0] TX_DATA,
  input wire TX_VALID,
  output wire TX_READY,
  output reg [7:0] RX_DATA,
  output reg RX_VALID,
  input wire RX_READY,
  input wire TERM_READY,
  input wire HW_FAULT,
  input wire FW_ERROR,
  input wire PARAM_ERROR,
  input wire REPARAM_BUSY,
  input wire FW_UPDATE,
  input wire RXD_PIN,
  input wire DSR_PIN,
  input wire CTS_PIN,
  input wire DCD_PIN,
  input wire RI_PIN,
  output reg TXD_PIN,
  output reg RTS_PIN,
  output reg DTR_PIN,
  output reg PARTNER_READY,
  output reg CARRIER,
  output reg RING,
  output reg BREAK_DET,
  output reg RX_OVERRUN,
  output reg FAULT_INDICATOR,
  output reg TX_INDICATOR,
  output reg RX_INDICATOR
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  wire rxd_s = sync2_q[0];
  wire dsr_s = sync2_q[1];
  wire cts_s = sync2_q[2];

  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      sync1_q <= 5'h01;
      sync2_q <= 5'h01;
    end
    else
    begin
      sync1_q <= {RI_PIN, DCD_PIN, CTS_PIN, DSR_PIN, RXD_PIN};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // Bit period, clamped to the top rate
  // ----------------------------------------
  wire [31:0] div_min_w = `RSP_DIV_MIN;
  wire [15:0] div_min = div_min_w[15:0];
  wire [15:0] div = (BAUD_DIV < div_min) ? div_min : BAUD_DIV;
  wire [15:0] div_half = {1'b0, div[15:1]};

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  wire [7:0] tb_data;
  wire tb_valid;
  reg tb_take;

  rsp_buf2 #(
    .W(8)
  ) u_txbuf (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .in_data(TX_DATA),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .out_data(tb_data),
    .out_valid(tb_valid),
    .out_ready(tb_take)
  );

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  localparam TX_IDLE = 3'b001;
  localparam TX_WAIT = 3'b010;
  localparam TX_SEND = 3'b100;
  reg [2:0] tx_st_q;
  reg [15:0] tx_cnt_q;
  reg [3:0] tx_bit_q;
  reg [9:0] tx_sh_q;
  reg tx_act;

  always @*
  begin
    tb_take = (tx_st_q == TX_WAIT) && cts_s;
    tx_act = (tx_st_q == TX_SEND);
  end

  // Independent of receiver below
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      TXD_PIN <= 1'b1;
      RTS_PIN <= 1'b0;
    end
    else
    begin
      case (tx_st_q)
        TX_IDLE:
        begin
          TXD_PIN <= 1'b1;
          RTS_PIN <= 1'b0;
          if (tb_valid)
          begin
            RTS_PIN <= 1'b1;
            tx_st_q <= TX_WAIT;
          end
        end
        TX_WAIT:
        begin
          if (tb_take)
          begin
            tx_sh_q <= {1'b1, tb_data, 1'b0};
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_st_q <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          TXD_PIN <= tx_sh_q[0];
          if (tx_cnt_q == div - 16'h0001)
          begin
            tx_cnt_q <= 16'h0000;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            if (tx_bit_q == 4'h9)
            begin
              // Keep request-to-send while more data waits
              tx_st_q <= tb_valid ? TX_WAIT : TX_IDLE;
              TXD_PIN <= 1'b1;
            end
            else
              tx_bit_q <= tx_bit_q + 4'h1;
          end
          else
            tx_cnt_q <= tx_cnt_q + 16'h0001;
        end
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  localparam RX_IDLE = 3'b001;
  localparam RX_BITS = 3'b010;
  localparam RX_STOP = 3'b100;
  reg [2:0] rx_st_q;
  reg [15:0] rx_cnt_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg [4:0] brk_bits_q;
  reg [15:0] brk_cnt_q;

  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      RX_DATA <= 8'h00;
      RX_VALID <= 1'b0;
      RX_OVERRUN <= 1'b0;
    end
    else
    begin
      if (RX_VALID && RX_READY)
        RX_VALID <= 1'b0;
      case (rx_st_q)
        RX_IDLE:
        begin
          // Idle line is one, start bit is a falling level
          if (!rxd_s)
          begin
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_st_q <= RX_BITS;
          end
        end
        RX_BITS:
        begin
          // Sample at middle of start bit, then every bit time
          if ((rx_bit_q == 4'h0) ? (rx_cnt_q == div_half) : (rx_cnt_q == div - 16'h0001))
          begin
            rx_cnt_q <= 16'h0000;
            if (rx_bit_q == 4'h0 && rxd_s)
              rx_st_q <= RX_IDLE;
            else if (rx_bit_q == 4'h9)
              rx_st_q <= RX_STOP;
            else
            begin
              if (rx_bit_q != 4'h0)
                rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
            end
            if (rx_bit_q == 4'h8)
              rx_bit_q <= 4'h9;
          end
          else
            rx_cnt_q <= rx_cnt_q + 16'h0001;
        end
        RX_STOP:
        begin
          // Bad stop bit drops the word; break logic reports long lows
          if (rxd_s)
          begin
            if (RX_VALID && !RX_READY)
              RX_OVERRUN <= 1'b1;
            else
            begin
              RX_DATA <= rx_sh_q;
              RX_VALID <= 1'b1;
            end
          end
          rx_st_q <= RX_IDLE;
        end
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Break detection and status
  // ----------------------------------------
  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      brk_cnt_q <= 16'h0000;
      brk_bits_q <= 5'h00;
      BREAK_DET <= 1'b0;
      PARTNER_READY <= 1'b0;
      CARRIER <= 1'b0;
      RING <= 1'b0;
      DTR_PIN <= 1'b0;
    end
    else
    begin
      PARTNER_READY <= dsr_s;
      CARRIER <= sync2_q[3];
      RING <= sync2_q[4];
      DTR_PIN <= TERM_READY;
      if (rxd_s)
      begin
        brk_cnt_q <= 16'h0000;
        brk_bits_q <= 5'h00;
        BREAK_DET <= 1'b0;
      end
      else if (brk_bits_q == `RSP_BRK_BITS)
        BREAK_DET <= 1'b1;
      else if (brk_cnt_q == div - 16'h0001)
      begin
        brk_cnt_q <= 16'h0000;
        brk_bits_q <= brk_bits_q + 5'h01;
      end
      else
        brk_cnt_q <= brk_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  reg [23:0] tx_led_q;
  reg [23:0] rx_led_q;
  wire rx_act = (rx_st_q != RX_IDLE);
  wire [31:0] led_cyc_w = `RSP_LED_CYC;
  wire [23:0] led_cyc = led_cyc_w[23:0];
  wire group_alarm = HW_FAULT | FW_ERROR | PARAM_ERROR | BREAK_DET;

  always @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      tx_led_q <= 24'h000000;
      rx_led_q <= 24'h000000;
      FAULT_INDICATOR <= 1'b0;
      TX_INDICATOR <= 1'b0;
      RX_INDICATOR <= 1'b0;
    end
    else
    begin
      // Stretch keeps a single short character visible
      if (tx_act)
        tx_led_q <= led_cyc;
      else if (tx_led_q != 24'h000000)
        tx_led_q <= tx_led_q - 24'h000001;
      if (rx_act)
        rx_led_q <= led_cyc;
      else if (rx_led_q != 24'h000000)
        rx_led_q <= rx_led_q - 24'h000001;
      FAULT_INDICATOR <= group_alarm | REPARAM_BUSY | FW_UPDATE;
      TX_INDICATOR <= FW_UPDATE | (tx_led_q != 24'h000000);
      RX_INDICATOR <= FW_UPDATE | (rx_led_q != 24'h000000);
    end
  end
endmodule

// File: testbench/rs232_port_handshake_status_bench.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Peer model on the cable side
// Notes: Divider below the floor is clamped to 3256, matching the peer's DIV
`timescale 1ns/1ps
module rs232_port_handshake_status_bench;
  localparam DIV = 3256;
  reg clk_sys, sys_rst, tx_valid, rx_ready, cts_en;
  reg [7:0] tx_data;
  reg [8:0] ctl;
  reg [15:0] rows [0:8];
  wire tx_ready, rx_valid, txd, rts, cts, rxd, brk, ovr;
  wire [7:0] rx_data, got, got_n;
  wire [6:0] stat;
  integer err_count, check_count, i, n;
  rsp_port rsp_port_i (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .BAUD_DIV(16'h0010),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .TERM_READY(ctl[8]), .HW_FAULT(ctl[7]),
    .FW_ERROR(ctl[6]), .PARAM_ERROR(ctl[5]), .REPARAM_BUSY(ctl[4]), .FW_UPDATE(ctl[3]),
    .RXD_PIN(rxd), .DSR_PIN(ctl[2]), .CTS_PIN(cts), .DCD_PIN(ctl[1]), .RI_PIN(ctl[0]),
    .TXD_PIN(txd), .RTS_PIN(rts), .DTR_PIN(stat[6]), .PARTNER_READY(stat[4]),
    .CARRIER(stat[3]), .RING(stat[2]), .BREAK_DET(brk), .RX_OVERRUN(ovr),
    .FAULT_INDICATOR(stat[5]), .TX_INDICATOR(stat[1]), .RX_INDICATOR(stat[0]));
  rsp_peer #(.DIV(DIV)) rsp_peer_i (.clk(clk_sys), .txd(txd), .rts(rts), .cts_en(cts_en),
    .rxd(rxd), .cts(cts), .got_q(got), .got_n(got_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task check(input [31:0] seen, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want)
      begin
        err_count = err_count + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task close_out;
    begin
      $display("Checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task tick(input integer k);
    repeat (k) @(negedge clk_sys);
  endtask
  task rst_pulse;
    begin
      sys_rst = 1'b1;
      tick(5);
      sys_rst = 1'b0;
      tick(1);
    end
  endtask
  // Bounded: a lost frame ends the run
  task wait_got;
    begin
      n = 0;
      while (got_n !== 8'h01 && n < 50000)
      begin
        tick(1);
        n = n + 1;
      end
      if (n == 50000)
      begin
        check(0, 1);
        close_out;
      end
    end
  endtask
  initial
  begin
    {tx_valid, rx_ready, cts_en, tx_data, ctl} = 0;
    sys_rst = 1'b1;
    err_count = 0;
    check_count = 0;
    // Rows: {term, hw, fw, param, reparam, update, dsr, dcd, ri} then expected lights
    rows[0] = 16'h0000;
    rows[1] = 16'h8250;
    rows[2] = 16'h4020;
    rows[3] = 16'h2020;
    rows[4] = 16'h1020;
    rows[5] = 16'h0820;
    rows[6] = 16'h018c;
    rows[7] = 16'h0423;
    rows[8] = 16'h0000;
    rst_pulse;
    check({txd, rts, tx_ready, ovr}, 4'b1010);
    for (i = 0; i < 9; i = i + 1)
    begin
      ctl = rows[i][15:7];
      tick(5);
      check(stat, rows[i][6:0]);
    end
    // ----
    // CTS withheld: fill until refused
    // ----
    tx_valid = 1'b1;
    n = 0;
    for (i = 0; i < 6; i = i + 1)
    begin
      tx_data = 8'h10 + i[7:0];
      if (tx_ready === 1'b1)
        n = n + 1;
      tick(1);
    end
    tx_valid = 1'b0;
    check({tx_ready, n == 2}, 2'b01);
    tick(300);
    check({txd, rts}, 2'b11);
    rst_pulse;
    check({tx_ready, txd, rts}, 3'b110);
    // ----
    // Both directions at once
    // ----
    cts_en = 1'b1;
    tx_data = 8'ha5;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    fork
      rsp_peer_i.send(8'h5a);
      wait_got;
    join
    tick(40);
    check(got, 8'ha5);
    check({rts, rx_valid, rx_data, stat[1:0]}, 12'h56b);
    check(ovr, 0);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    check(rx_valid, 0);
    // ----
    // Receive line held low: break
    // ----
    fork
      rsp_peer_i.brk(20 * DIV + 300);
      tick(20 * DIV + 200);
    join_any
    check({brk, stat[5]}, 2'b11);
    tick(120);
    check({brk, stat[5]}, 2'b00);
    close_out;
  end
endmodule

// File: testbench/rsp_peer.sv
// Purpose: Cable partner: answers RTS, decodes TXD, sends on RXD
// Assumes: 8N1 at DIV clocks per bit
// Notes: Decoder ignores edges inside a frame
`timescale 1ns/1ps
module rsp_peer #(
  parameter DIV = 3256
) (
  input wire clk,
  input wire txd,
  input wire rts,
  input wire cts_en,
  output reg rxd,
  output reg cts,
  output reg [7:0] got_q,
  output reg [7:0] got_n
);
  initial
  begin
    rxd = 1'b1;
    cts = 1'b0;
    got_q = 8'h00;
    got_n = 8'h00;
  end
  // Slow answer possible: cts_en low withholds CTS
  always @(posedge clk)
    cts <= rts & cts_en;
  always @(negedge txd)
  begin : decode
    integer i;
    repeat (DIV / 2) @(posedge clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      repeat (DIV) @(posedge clk);
      got_q[i] = txd;
    end
    repeat (DIV) @(posedge clk);
    got_n = got_n + 8'h01;
  end
  task send(input [7:0] b);
    integer i;
    begin
      rxd <= 1'b0;
      repeat (DIV) @(posedge clk);
      for (i = 0; i < 8; i = i + 1)
      begin
        rxd <= b[i];
        repeat (DIV) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (DIV) @(posedge clk);
    end
  endtask
  task brk(input integer cyc);
    begin
      rxd <= 1'b0;
      repeat (cyc) @(posedge clk);
      rxd <= 1'b1;
    end
  endtask
endmodule

// File: testbench/rsp_port_chk.sv
// Purpose: Concurrent checks on the serial port pins and indicators
// Assumes: Bound to rsp_port, one clock domain
// Notes: DSR, DCD and RI pass-through checks wait three clean edges after reset
`timescale 1ns/1ps
module rsp_port_chk (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire TERM_READY,
  input wire HW_FAULT,
  input wire FW_ERROR,
  input wire PARAM_ERROR,
  input wire REPARAM_BUSY,
  input wire FW_UPDATE,
  input wire DSR_PIN,
  input wire CTS_PIN,
  input wire DCD_PIN,
  input wire RI_PIN,
  input wire TX_VALID,
  input wire TX_READY,
  input wire [7:0] RX_DATA,
  input wire RX_VALID,
  input wire RX_READY,
  input wire TXD_PIN,
  input wire RTS_PIN,
  input wire DTR_PIN,
  input wire PARTNER_READY,
  input wire CARRIER,
  input wire RING,
  input wire BREAK_DET,
  input wire FAULT_INDICATOR,
  input wire TX_INDICATOR,
  input wire RX_INDICATOR
);
  // Clean edges since reset, so $past never sees reset values
  reg [2:0] up_q;
  always @(posedge CLK_SYS)
    up_q <= SYS_RST ? 3'h0 : {up_q[1:0], 1'b1};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  line_busy_a: assert property (!TXD_PIN |-> RTS_PIN)
    else $error("TXD low without RTS");
  cts_gate_a: assert property ($fell(TXD_PIN) |-> $past(CTS_PIN, 4))
    else $error("Bit sent without CTS");
  rts_drop_a: assert property ($fell(RTS_PIN) |-> TXD_PIN && $past(TXD_PIN))
    else $error("RTS dropped mid frame");
  ready_pass_a: assert property (up_q == 3'h7 |-> PARTNER_READY == $past(DSR_PIN, 3))
    else $error("Partner ready wrong");
  modem_pass_a: assert property (up_q == 3'h7 |->
    CARRIER == $past(DCD_PIN, 3) && RING == $past(RI_PIN, 3))
    else $error("Carrier or ring wrong");
  dtr_pass_a: assert property (up_q[0] |-> DTR_PIN == $past(TERM_READY))
    else $error("DTR wrong");
  fault_led_a: assert property (up_q[0] && !BREAK_DET && !$past(BREAK_DET) |->
    FAULT_INDICATOR == ($past(HW_FAULT) | $past(FW_ERROR) | $past(PARAM_ERROR) |
    $past(REPARAM_BUSY) | $past(FW_UPDATE)))
    else $error("Fault light wrong");
  break_led_a: assert property (BREAK_DET |-> ##[0:1] FAULT_INDICATOR)
    else $error("Break without fault light");
  update_leds_a: assert property (up_q[0] && $past(FW_UPDATE) |->
    TX_INDICATOR && RX_INDICATOR && FAULT_INDICATOR)
    else $error("Update lights wrong");
  tx_flash_a: assert property ($fell(TXD_PIN) |-> ##[0:2] TX_INDICATOR)
    else $error("Send light dark");
  rx_flash_a: assert property ($rose(RX_VALID) |-> RX_INDICATOR)
    else $error("Receive light dark");
  rx_hold_a: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
    else $error("Received byte lost");
  cover property ($fell(TXD_PIN));
  cover property ($rose(RX_VALID));
  cover property (TX_VALID && !TX_READY);
  cover property ($rose(BREAK_DET));
endmodule
bind rsp_port rsp_port_chk rsp_port_chk_i (.CLK_SYS, .SYS_RST, .TERM_READY, .HW_FAULT,
  .FW_ERROR, .PARAM_ERROR, .REPARAM_BUSY, .FW_UPDATE, .DSR_PIN, .CTS_PIN, .DCD_PIN,
  .RI_PIN, .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID, .RX_READY, .TXD_PIN, .RTS_PIN,
  .DTR_PIN, .PARTNER_READY, .CARRIER, .RING, .BREAK_DET, .FAULT_INDICATOR,
  .TX_INDICATOR, .RX_INDICATOR);
